// >>> shared/asr_pkg.sv
// Package with register addresses, field layouts and widths of the core SFR block.
package asr_pkg;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned SECTOR_W    = 4;
    localparam int unsigned PC_W        = 16;
    localparam int unsigned PROG_W      = 16;
    localparam int unsigned BANK_W      = 3;
    localparam int unsigned PAGE_W      = 8;
    localparam int unsigned RAM_DEPTH   = 4096;

    localparam logic [7:0] OFS_WIN0     = 8'h00;
    localparam logic [7:0] OFS_PTR0     = 8'h01;
    localparam logic [7:0] OFS_WIN1     = 8'h02;
    localparam logic [7:0] OFS_PTR1_LO  = 8'h03;
    localparam logic [7:0] OFS_PTR1_SEC = 8'h04;
    localparam logic [7:0] OFS_ACC      = 8'h05;
    localparam logic [7:0] OFS_PCL      = 8'h06;
    localparam logic [7:0] OFS_TBL_LO   = 8'h07;
    localparam logic [7:0] OFS_TBL_RES  = 8'h08;
    localparam logic [7:0] OFS_TBL_HI   = 8'h09;
    localparam logic [7:0] OFS_BANK     = 8'h0b;
    localparam logic [7:0] OFS_WIN2     = 8'h0c;
    localparam logic [7:0] OFS_PTR2_LO  = 8'h0d;
    localparam logic [7:0] OFS_PTR2_SEC = 8'h0e;

    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [7:0] WIN_READ_VAL = 8'h00;
    localparam logic [3:0] SECTOR_ZERO  = 4'h0;
    localparam logic [7:0] BYTE_ONE     = 8'h01;

    // Request kinds issued by the instruction sequencer.
    typedef enum logic [3:0] {
        ASR_OP_NONE  = 4'h0,
        ASR_OP_READ  = 4'h1,
        ASR_OP_WRITE = 4'h2,
        ASR_OP_INC   = 4'h3,
        ASR_OP_DEC   = 4'h4,
        ASR_OP_ALU   = 4'h5,
        ASR_OP_JUMP  = 4'h6,
        ASR_OP_TABRD = 4'h7
    } asr_op_t;

    typedef enum logic [2:0] {
        ASR_ST_RUN   = 3'b001,
        ASR_ST_DUMMY = 3'b010,
        ASR_ST_TABLE = 3'b100
    } asr_state_t;
endpackage

// >>> shared/asr_ram_if.sv
// Interface carrying the data-memory port between the SFR core and its RAM.
`timescale 1ns/1ps
`default_nettype none
interface asr_ram_if;
    logic        we;
    logic        re;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    modport core (output we, output re, output addr, output wdata,
                  input rdata);
    modport mem  (input we, input re, input addr, input wdata,
                  output rdata);
endinterface
`default_nettype wire

// >>> core/asr_ram.sv
// Data memory of the core; read data come out of a register.
`timescale 1ns/1ps
`default_nettype none
module asr_ram (
    input  wire logic clock,
    input  wire logic clk_en,
    asr_ram_if.mem    port
);
    import asr_pkg::*;

    logic [DATA_W-1:0] mem_q [RAM_DEPTH];
    logic [DATA_W-1:0] rd_q;

    always_ff @(posedge clock) begin
        if (clk_en) begin
            if (port.we) begin
                mem_q[port.addr] <= port.wdata;
            end
            if (port.re) begin
                rd_q <= mem_q[port.addr];
            end
        end
    end

    assign port.rdata = rd_q;
endmodule
`default_nettype wire

// >>> core/asr_core.sv
// Special-function registers for data and program addressing of the core.
// Overview of operation
// - Window access acts on pointed memory location
// - First window confined to sector zero
// - Other windows: sector byte plus low byte
// - Window through window reads zero, ignores writes
// - Pointer bytes are readable writable storage
// - Extended direct address reaches every sector
// - Jump lands inside currently selected bank
// - Low bank bits number the bank
// - Upper bank bits are plain storage
// - Accumulator takes ALU results and moves
// - Low counter byte write jumps within page
// - Low counter byte write adds dummy cycle
// - Table pointer pair forms table address
// - Table read splits word high and low
`timescale 1ns/1ps
`default_nettype none
module asr_core (
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire logic                      clk_en,
    input  wire asr_pkg::asr_op_t          op,
    input  wire logic                      op_ext,
    input  wire logic [asr_pkg::ADDR_W-1:0] op_addr,
    input  wire logic [asr_pkg::DATA_W-1:0] op_wdata,
    input  wire logic                      op_to_acc,
    input  wire logic [asr_pkg::DATA_W-1:0] alu_result,
    input  wire logic [asr_pkg::PC_W-1:0]   jump_target,
    input  wire logic [asr_pkg::PROG_W-1:0] prog_word,
    output logic                           op_ready,
    output logic [asr_pkg::DATA_W-1:0]      rd_data,
    output logic                           rd_valid,
    output logic [asr_pkg::DATA_W-1:0]      acc,
    output logic [asr_pkg::PC_W-1:0]        pc,
    output logic                           pc_load,
    output logic                           dummy_cycle,
    output logic [asr_pkg::PC_W-1:0]        table_addr,
    output logic [asr_pkg::DATA_W-1:0]      bank_select
);
    import asr_pkg::*;

    typedef struct packed {
        asr_state_t            st;
        logic [DATA_W-1:0]     acc;
        logic [DATA_W-1:0]     p0;
        logic [DATA_W-1:0]     p1l;
        logic [DATA_W-1:0]     p1h;
        logic [DATA_W-1:0]     p2l;
        logic [DATA_W-1:0]     p2h;
        logic [DATA_W-1:0]     bank;
        logic [DATA_W-1:0]     tbl_lo;
        logic [DATA_W-1:0]     tbl_hi;
        logic [DATA_W-1:0]     tbl_res;
        logic [PC_W-1:0]       pc;
        logic                  pc_load;
        logic                  dummy;
        logic                  ready;
        logic                  rd_pend;
        logic                  rd_mem;
        logic                  rd_acc;
        logic                  rd_valid;
        logic [DATA_W-1:0]     rd_data;
        logic [DATA_W-1:0]     rd_hold;
    } asr_state_reg_t;

    asr_state_reg_t s_q;
    asr_state_reg_t s_d;

    asr_ram_if ram ();

    asr_ram u_ram (
        .clock  (clock),
        .clk_en (clk_en),
        .port   (ram.mem)
    );

    // Classifies a special-register byte address as one of the windows.
    function automatic logic is_window(input logic [ADDR_W-1:0] a);
        return (a[ADDR_W-1:DATA_W] == SECTOR_ZERO) &&
               (a[DATA_W-1:0] == OFS_WIN0 || a[DATA_W-1:0] == OFS_WIN1 ||
                a[DATA_W-1:0] == OFS_WIN2);
    endfunction

    function automatic logic is_sfr(input logic [ADDR_W-1:0] a,
                                    input logic [DATA_W-1:0] o);
        return (a[ADDR_W-1:DATA_W] == SECTOR_ZERO) && (a[DATA_W-1:0] == o);
    endfunction

    logic [ADDR_W-1:0] eff_addr;
    logic              via_window;
    logic              blocked;
    logic [DATA_W-1:0] cur_val;
    logic [DATA_W-1:0] new_val;
    logic              is_reg;

    // Resolve the effective address, following a window to its pointer.
    always_comb begin
        via_window = 1'b0;
        // Short addresses always fall in sector zero, so the window test
        // looks at the resolved address and not at the raw upper bits.
        eff_addr   = op_ext ? op_addr : {SECTOR_ZERO, op_addr[DATA_W-1:0]};
        if (is_sfr(eff_addr, OFS_WIN0)) begin
            via_window = 1'b1;
            eff_addr   = {SECTOR_ZERO, s_q.p0};
        end else if (is_sfr(eff_addr, OFS_WIN1)) begin
            via_window = 1'b1;
            eff_addr   = {s_q.p1h[SECTOR_W-1:0], s_q.p1l};
        end else if (is_sfr(eff_addr, OFS_WIN2)) begin
            via_window = 1'b1;
            eff_addr   = {s_q.p2h[SECTOR_W-1:0], s_q.p2l};
        end
        blocked = via_window && is_window(eff_addr);
    end

    // Current value of a special register, when the target is one.
    always_comb begin
        is_reg  = 1'b1;
        cur_val = RST_BYTE;
        if (eff_addr[ADDR_W-1:DATA_W] != SECTOR_ZERO) begin
            is_reg = 1'b0;
        end else begin
            case (eff_addr[DATA_W-1:0])
                OFS_PTR0:     cur_val = s_q.p0;
                OFS_PTR1_LO:  cur_val = s_q.p1l;
                OFS_PTR1_SEC: cur_val = s_q.p1h;
                OFS_PTR2_LO:  cur_val = s_q.p2l;
                OFS_PTR2_SEC: cur_val = s_q.p2h;
                OFS_ACC:      cur_val = s_q.acc;
                OFS_PCL:      cur_val = s_q.pc[PAGE_W-1:0];
                OFS_TBL_LO:   cur_val = s_q.tbl_lo;
                OFS_TBL_RES:  cur_val = s_q.tbl_res;
                OFS_TBL_HI:   cur_val = s_q.tbl_hi;
                OFS_BANK:     cur_val = s_q.bank;
                OFS_WIN0, OFS_WIN1, OFS_WIN2: cur_val = WIN_READ_VAL;
                default:      is_reg  = 1'b0;
            endcase
        end
        case (op)
            ASR_OP_INC: new_val = cur_val + BYTE_ONE;
            ASR_OP_DEC: new_val = cur_val - BYTE_ONE;
            default:    new_val = op_wdata;
        endcase
    end

    // Sequencing of register updates and data-memory traffic.
    always_comb begin
        s_d          = s_q;
        s_d.pc_load  = 1'b0;
        s_d.dummy    = 1'b0;
        s_d.rd_valid = 1'b0;
        s_d.rd_pend  = 1'b0;
        ram.we       = 1'b0;
        ram.re       = 1'b0;
        ram.addr     = eff_addr;
        ram.wdata    = op_wdata;
        if (s_q.rd_pend) begin
            s_d.rd_valid = 1'b1;
            s_d.rd_data  = s_q.rd_mem ? ram.rdata : s_q.rd_hold;
            if (s_q.rd_acc) begin
                s_d.acc = s_d.rd_data;
            end
        end
        case (s_q.st)
            ASR_ST_RUN: begin
                case (op)
                    ASR_OP_READ: begin
                        s_d.rd_pend = 1'b1;
                        s_d.rd_acc  = op_to_acc;
                        s_d.rd_mem  = !blocked && !is_reg;
                        // A register value waits in its own byte, so a read
                        // taken in the answer cycle of another cannot
                        // overwrite the result on its way out.
                        s_d.rd_hold = blocked ? WIN_READ_VAL : cur_val;
                        ram.re      = !blocked && !is_reg;
                    end
                    ASR_OP_WRITE, ASR_OP_INC, ASR_OP_DEC: begin
                        if (!blocked && (op == ASR_OP_WRITE || is_reg)) begin
                            if (!is_reg) begin
                                ram.we = 1'b1;
                            end else begin
                                case (eff_addr[DATA_W-1:0])
                                    OFS_PTR0:     s_d.p0     = new_val;
                                    OFS_PTR1_LO:  s_d.p1l    = new_val;
                                    OFS_PTR1_SEC: s_d.p1h    = new_val;
                                    OFS_PTR2_LO:  s_d.p2l    = new_val;
                                    OFS_PTR2_SEC: s_d.p2h    = new_val;
                                    OFS_ACC:      s_d.acc    = new_val;
                                    OFS_TBL_LO:   s_d.tbl_lo = new_val;
                                    OFS_TBL_HI:   s_d.tbl_hi = new_val;
                                    OFS_TBL_RES:  s_d.tbl_res = new_val;
                                    OFS_BANK:     s_d.bank   = new_val;
                                    OFS_PCL: begin
                                        s_d.pc[PAGE_W-1:0] = new_val;
                                        s_d.pc_load = 1'b1;
                                        s_d.dummy   = 1'b1;
                                        s_d.ready   = 1'b0;
                                        s_d.st      = ASR_ST_DUMMY;
                                    end
                                    default: ;
                                endcase
                            end
                        end
                    end
                    ASR_OP_ALU: begin
                        s_d.acc = alu_result;
                    end
                    ASR_OP_JUMP: begin
                        s_d.pc = {jump_target[PC_W-1:PC_W-BANK_W] &
                                  {BANK_W{1'b0}} | s_q.bank[BANK_W-1:0],
                                  jump_target[PC_W-BANK_W-1:0]};
                        s_d.pc_load = 1'b1;
                    end
                    ASR_OP_TABRD: begin
                        s_d.ready = 1'b0;
                        s_d.st    = ASR_ST_TABLE;
                    end
                    default: ;
                endcase
            end
            ASR_ST_DUMMY: begin
                s_d.ready = 1'b1;
                s_d.st    = ASR_ST_RUN;
            end
            ASR_ST_TABLE: begin
                s_d.tbl_res = prog_word[PROG_W-1:DATA_W];
                ram.we      = !blocked && !is_reg;
                ram.wdata   = prog_word[DATA_W-1:0];
                if (is_reg && !blocked &&
                    eff_addr[DATA_W-1:0] == OFS_ACC) begin
                    s_d.acc = prog_word[DATA_W-1:0];
                end
                s_d.ready = 1'b1;
                s_d.st    = ASR_ST_RUN;
            end
            default: begin
                s_d.st    = ASR_ST_RUN;
                s_d.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q       <= '0;
            s_q.st    <= ASR_ST_RUN;
            s_q.ready <= 1'b1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign op_ready    = s_q.ready;
    assign rd_data     = s_q.rd_data;
    assign rd_valid    = s_q.rd_valid;
    assign acc         = s_q.acc;
    assign pc          = s_q.pc;
    assign pc_load     = s_q.pc_load;
    assign dummy_cycle = s_q.dummy;
    assign bank_select = s_q.bank;
    assign table_addr  = {s_q.tbl_hi, s_q.tbl_lo};

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n || !clk_en);

    a_pcl_dummy_cycle: assert property (
        (op == ASR_OP_WRITE && is_sfr(op_addr, OFS_PCL) && op_ready)
        |=> dummy_cycle && !op_ready ##1 op_ready)
        else $error("missing dummy cycle after low counter write");
    a_pcl_page_kept: assert property (
        (op == ASR_OP_WRITE && is_sfr(op_addr, OFS_PCL) && op_ready)
        |=> pc == {$past(pc[PC_W-1:PAGE_W]), $past(op_wdata)})
        else $error("low counter write left page or lost value");
    a_jump_in_bank: assert property (
        (op == ASR_OP_JUMP && op_ready)
        |=> pc[PC_W-1:PC_W-BANK_W] == $past(bank_select[BANK_W-1:0]))
        else $error("jump left selected bank");
    a_bank_stored: assert property (
        (op == ASR_OP_WRITE && is_sfr(op_addr, OFS_BANK) && op_ready)
        |=> bank_select == $past(op_wdata))
        else $error("bank byte not stored");
    a_window_reads_zero: assert property (
        (op == ASR_OP_READ && blocked && op_ready)
        |=> ##1 rd_valid && rd_data == WIN_READ_VAL)
        else $error("window through window not zero");
    a_alu_to_acc: assert property (
        (op == ASR_OP_ALU && op_ready) |=> acc == $past(alu_result))
        else $error("accumulator missed result");
    a_ptr_wrap: assert property (
        (op == ASR_OP_INC && is_sfr(op_addr, OFS_PTR1_LO) && op_ready)
        |=> s_q.p1l == $past(s_q.p1l) + BYTE_ONE && $stable(s_q.p1h))
        else $error("pointer increment wrong");
    a_table_high: assert property (
        (op == ASR_OP_TABRD && op_ready)
        |=> ##1 s_q.tbl_res == $past(prog_word[PROG_W-1:DATA_W]))
        else $error("table high byte wrong");
    a_window_ram_addr: assert property (
        (op == ASR_OP_WRITE && is_sfr(op_addr, OFS_WIN0) && ram.we)
        |-> ram.addr[ADDR_W-1:DATA_W] == SECTOR_ZERO)
        else $error("first window left sector zero");

    c_pcl_write: cover property (op == ASR_OP_WRITE &&
                                 is_sfr(op_addr, OFS_PCL) && op_ready);
    c_table_read: cover property (op == ASR_OP_TABRD && op_ready);
    c_window_read: cover property (op == ASR_OP_READ && via_window);
    c_jump: cover property (op == ASR_OP_JUMP && op_ready);
endmodule
`default_nettype wire

// >>> tb/asr_core_tb.sv
// Self-checking bench for the addressing special-function registers.
`timescale 1ns/1ps
`default_nettype none
module asr_core_tb;
    import asr_pkg::*;

    logic              clock;
    logic              rst_n;
    logic              clk_en;
    asr_op_t           op;
    logic              op_ext;
    logic [ADDR_W-1:0] op_addr;
    logic [DATA_W-1:0] op_wdata;
    logic              op_to_acc;
    logic [DATA_W-1:0] alu_result;
    logic [PC_W-1:0]   jump_target;
    logic [PROG_W-1:0] prog_word;
    logic              op_ready;
    logic [DATA_W-1:0] rd_data;
    logic              rd_valid;
    logic [DATA_W-1:0] acc;
    logic [PC_W-1:0]   pc;
    logic              pc_load;
    logic              dummy_cycle;
    logic [PC_W-1:0]   table_addr;
    logic [DATA_W-1:0] bank_select;
    int                bad_count;
    int                comparisons;
    logic [31:0]       seed;
    logic [7:0]        a;
    logic [7:0]        b;
    logic [7:0]        c;
    logic [15:0]       pc_old;

    asr_core i_asr_core (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .op(op),
        .op_ext(op_ext),
        .op_addr(op_addr),
        .op_wdata(op_wdata),
        .op_to_acc(op_to_acc),
        .alu_result(alu_result),
        .jump_target(jump_target),
        .prog_word(prog_word),
        .op_ready(op_ready),
        .rd_data(rd_data),
        .rd_valid(rd_valid),
        .acc(acc),
        .pc(pc),
        .pc_load(pc_load),
        .dummy_cycle(dummy_cycle),
        .table_addr(table_addr),
        .bank_select(bank_select)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic conclude();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h / %h", $time, seen, exp);
        end
    endtask

    // One xorshift step; the fixed start value keeps runs repeatable.
    function automatic logic [31:0] xorshift(logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        t = t ^ (t << 5);
        return t;
    endfunction

    task automatic rnd(output logic [7:0] v);
        seed = xorshift(seed);
        v = seed[7:0];
    endtask

    function automatic logic [11:0] s0(logic [7:0] o);
        return {4'h0, o};
    endfunction

    // Bank bits replace the top of the jump target.
    function automatic logic [15:0] jexp(logic [7:0] bk, logic [15:0] t);
        return {bk[2:0], t[12:0]};
    endfunction

    // Request is raised after one edge and taken at the next; it stays up
    // so that a following request replaces it without a double drive.
    task automatic req(asr_op_t o, logic [11:0] ad, logic [7:0] wd);
        op <= o;
        op_ext <= |ad[11:8];
        op_addr <= ad;
        op_wdata <= wd;
        @(posedge clock);
    endtask

    // Lowers the request and lets one edge pass.
    task automatic idle();
        op <= ASR_OP_NONE;
        @(posedge clock);
    endtask

    task automatic rd(logic [11:0] ad, logic [7:0] ex);
        req(ASR_OP_READ, ad, 8'h00);
        idle();
        #1;
        chk(rd_valid, 1'b1);
        chk(rd_data, ex);
        idle();
    endtask

    // Program word is wrong except in the cycle where it is sampled.
    task automatic tabrd(logic [11:0] ad, logic [15:0] pw);
        prog_word <= ~pw;
        req(ASR_OP_TABRD, ad, 8'h00);
        op <= ASR_OP_NONE;
        prog_word <= pw;
        #1;
        chk(op_ready, 1'b0);
        @(posedge clock);
        prog_word <= ~pw;
    endtask

    initial begin
        repeat (4000) @(posedge clock);
        bad_count++;
        conclude();
    end

    initial begin
        {rst_n, op_ext, op_addr, op_wdata, op_to_acc} = '0;
        {alu_result, jump_target, prog_word} = '0;
        op = ASR_OP_NONE;
        clk_en = 1'b1;
        bad_count = 0;
        comparisons = 0;
        seed = 32'd72;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        chk(bank_select, 8'h00);
        chk(table_addr, 16'h0000);
        chk(op_ready, 1'b1);
        @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            rnd(a);
            rnd(b);
            rnd(c);
            a = a | 8'h80;
            req(ASR_OP_WRITE, {4'h1, a}, b);
            req(ASR_OP_WRITE, s0(OFS_PTR0), a);
            rd(s0(OFS_PTR0), a);
            req(ASR_OP_WRITE, s0(OFS_WIN0), c);
            rd(s0(a), c);
            rd({4'h1, a}, b);
            rd(s0(OFS_WIN0), c);
        end
        for (int k = 0; k < 2; k++) begin
            rnd(a);
            rnd(b);
            c = k ? OFS_PTR2_LO : OFS_PTR1_LO;
            req(ASR_OP_WRITE, s0(c + 8'h01), {4'h0, a[3:0]});
            req(ASR_OP_WRITE, s0(c), 8'hff);
            req(ASR_OP_WRITE, s0(c - 8'h01), b);
            rd({a[3:0], 8'hff}, b);
            req(ASR_OP_INC, s0(c), 8'h00);
            rd(s0(c), 8'h00);
            rd(s0(c + 8'h01), {4'h0, a[3:0]});
            req(ASR_OP_DEC, s0(c), 8'h00);
            rd(s0(c - 8'h01), b);
        end
        req(ASR_OP_WRITE, s0(OFS_PTR0), OFS_WIN1);
        req(ASR_OP_WRITE, s0(OFS_WIN0), 8'h5a);
        rd(s0(OFS_WIN0), WIN_READ_VAL);
        rd(s0(OFS_PTR0), OFS_WIN1);
        req(ASR_OP_WRITE, s0(OFS_PTR1_SEC), 8'h00);
        req(ASR_OP_WRITE, s0(OFS_PTR1_LO), OFS_WIN2);
        req(ASR_OP_WRITE, s0(OFS_WIN1), 8'ha5);
        rd(s0(OFS_WIN1), WIN_READ_VAL);
        for (int k = 0; k < 8; k++) begin
            rnd(a);
            rnd(b);
            a = {a[7:3], 3'(k)};
            req(ASR_OP_WRITE, s0(OFS_BANK), a);
            rd(s0(OFS_BANK), a);
            jump_target <= seed[23:8];
            req(ASR_OP_JUMP, 12'h000, 8'h00);
            #1;
            chk(bank_select, a);
            chk(pc, jexp(a, jump_target));
            chk(pc_load, 1'b1);
            idle();
        end
        rnd(a);
        pc_old = pc;
        req(ASR_OP_WRITE, s0(OFS_PCL), a);
        #1;
        chk(pc, {pc_old[15:8], a});
        chk(pc_load, 1'b1);
        chk(dummy_cycle, 1'b1);
        chk(op_ready, 1'b0);
        idle();
        #1;
        chk(dummy_cycle, 1'b0);
        chk(op_ready, 1'b1);
        rnd(a);
        rnd(b);
        alu_result <= a;
        req(ASR_OP_ALU, 12'h000, 8'h00);
        #1;
        chk(acc, a);
        req(ASR_OP_WRITE, s0(8'h90), b);
        op_to_acc <= 1'b1;
        rd(s0(8'h90), b);
        op_to_acc <= 1'b0;
        chk(acc, b);
        req(ASR_OP_WRITE, s0(8'h91), acc);
        rd(s0(8'h91), b);
        rd(s0(OFS_ACC), b);
        rnd(a);
        rnd(b);
        a[0] = 1'b0;
        req(ASR_OP_WRITE, s0(OFS_TBL_LO), a);
        req(ASR_OP_WRITE, s0(OFS_TBL_HI), b);
        #1;
        chk(table_addr, {b, a});
        req(ASR_OP_INC, s0(OFS_TBL_LO), 8'h00);
        #1;
        chk(table_addr, {b, a + 8'h01});
        tabrd(s0(8'ha0), {b, a});
        rd(s0(OFS_TBL_RES), b);
        rd(s0(8'ha0), a);
        // A write issued while the enable is low must leave no trace.
        req(ASR_OP_WRITE, s0(OFS_BANK), 8'h5c);
        clk_en <= 1'b0;
        req(ASR_OP_WRITE, s0(OFS_BANK), 8'ha3);
        idle();
        #1;
        chk(bank_select, 8'h5c);
        clk_en <= 1'b1;
        @(posedge clock);
        rst_n <= 1'b0;
        @(posedge clock);
        #1;
        chk(bank_select, 8'h00);
        chk(acc, 8'h00);
        chk(pc, 16'h0000);
        chk(op_ready, 1'b1);
        conclude();
    end
endmodule
`default_nettype wire
